// file: ext_irq4_edge_detect_ctrl.v
// external interrupt 4 noise filter, trigger detect and control register on AHB-Lite
`timescale 1ns/100ps
`include "ext_irq4_regs.vh"
//
// Summary of operation
// - 8-bit control register at 0x0FDB; bits 7-5, 4 read-only; reset zero.
// - bit 4 holds the filtered level captured when a request was raised.
// - trigger code 00 raises a request on each rising filtered edge.
// - trigger code 01 raises a request on each falling filtered edge.
// - trigger code comes from bits 3-2, writable any time.
// - trigger code 10 raises a request on both filtered edges.
// - trigger code 11 raises requests while the filtered signal is high.
// - bits 1-0 set filter sample rate: gear/1,4,8,16 fast; low clock/4 slow.
//
module ext_irq4_edge_detect_ctrl (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [13:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire extPin,
  input wire gearClkEn,
  input wire lowFreqClkEn,
  input wire slowMode,
  output reg irqReq,
  output reg intOut
);

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  reg [1:0] trigSel_r;
  reg [1:0] smpSel_r;
  reg levelFlag_r;
  reg [7:0] stat_r;
  reg [7:0] mask_r;
  reg wrPend_r;
  reg rdPend_r;
  reg [13:0] addrHold_r;
  reg [3:0] gearCnt_r;
  reg [1:0] slowCnt_r;
  reg [2:0] runCnt_r;
  reg smpLast_r;
  reg filt_r;
  reg filtDly_r;

  wire addrPhase;
  wire [7:0] ctrlView;
  wire smpTick;
  wire gearTick;
  wire slowTick;
  wire reqEvent;
  wire statRdClr;

  assign addrPhase = hsel & hready & htrans[1];
  assign ctrlView = {3'h0, levelFlag_r, trigSel_r, smpSel_r};

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  function [31:0] readMux;
    input [13:0] a;
    input [7:0] ctrlV;
    input [7:0] statV;
    input [7:0] maskV;
    begin
      case (a)
        `CTRL_ADDR: readMux = {24'h000000, ctrlV};
        `STAT_ADDR: readMux = {24'h000000, statV};
        `MASK_ADDR: readMux = {24'h000000, maskV};
        default: readMux = 32'h00000000;
      endcase
    end
  endfunction

  // gear clock divide mask: code 0 -> /1, 1 -> /4, 2 -> /8, 3 -> /16
  function gearHit;
    input [1:0] code;
    input [3:0] cnt;
    begin
      case (code)
        2'h0: gearHit = 1'b1;
        2'h1: gearHit = (cnt[1:0] == 2'h3);
        2'h2: gearHit = (cnt[2:0] == 3'h7);
        default: gearHit = (cnt == 4'hF);
      endcase
    end
  endfunction

  // true when a live or held byte address selects the given register word
  function regHit;
    input [13:0] a;
    input [13:0] regA;
    begin
      regHit = (a == regA);
    end
  endfunction

  // ------------------------------------------------------------------
  // AHB-Lite slave: zero wait states, always OKAY
  // ------------------------------------------------------------------
  reg wrPend_nxt;
  reg rdPend_nxt;
  reg [13:0] addrHold_nxt;
  always @* begin
    wrPend_nxt = addrPhase & hwrite;
    rdPend_nxt = addrPhase & ~hwrite;
    addrHold_nxt = addrHold_r;
    if (addrPhase) begin
      addrHold_nxt = haddr;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      wrPend_r <= 1'b0;
      rdPend_r <= 1'b0;
      addrHold_r <= 14'h0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wrPend_r <= wrPend_nxt;
      rdPend_r <= rdPend_nxt;
      addrHold_r <= addrHold_nxt;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  // read data registered in the address phase so it stands in the data phase
  always @(posedge mclk) begin
    if (rst) begin
      hrdata <= 32'h00000000;
    end else if (addrPhase & ~hwrite) begin
      hrdata <= readMux(haddr, ctrlView, stat_r, mask_r);
    end
  end

  assign statRdClr = addrPhase & ~hwrite & regHit(haddr, `STAT_ADDR);

  // ------------------------------------------------------------------
  // control and mask registers
  // ------------------------------------------------------------------
  reg [1:0] trigSel_nxt;
  reg [1:0] smpSel_nxt;
  reg [7:0] mask_nxt;
  always @* begin
    trigSel_nxt = trigSel_r;
    smpSel_nxt = smpSel_r;
    mask_nxt = mask_r;
    if (wrPend_r && regHit(addrHold_r, `CTRL_ADDR)) begin
      trigSel_nxt = hwdata[`TRIG_HI:`TRIG_LO];
      smpSel_nxt = hwdata[`SMP_HI:`SMP_LO];
    end
    if (wrPend_r && regHit(addrHold_r, `MASK_ADDR)) begin
      mask_nxt = hwdata[7:0];
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      trigSel_r <= `TRIG_RESET;
      smpSel_r <= `SMP_RESET;
      mask_r <= `MASK_RESET;
    end else begin
      trigSel_r <= trigSel_nxt;
      smpSel_r <= smpSel_nxt;
      mask_r <= mask_nxt;
    end
  end

  // ------------------------------------------------------------------
  // noise canceller sampling enable
  // ------------------------------------------------------------------
  reg [3:0] gearCnt_nxt;
  reg [1:0] slowCnt_nxt;
  always @* begin
    gearCnt_nxt = gearCnt_r;
    slowCnt_nxt = slowCnt_r;
    if (gearClkEn) begin
      gearCnt_nxt = gearCnt_r + 4'h1;
    end
    if (lowFreqClkEn) begin
      slowCnt_nxt = slowCnt_r + 2'h1;
    end
  end

  always @(posedge mclk) begin
    if (rst) begin
      gearCnt_r <= 4'h0;
      slowCnt_r <= 2'h0;
    end else begin
      gearCnt_r <= gearCnt_nxt;
      slowCnt_r <= slowCnt_nxt;
    end
  end

  assign gearTick = gearClkEn & gearHit(smpSel_r, gearCnt_r);
  assign slowTick = lowFreqClkEn & (slowCnt_r == `SLOW_DIV);
  assign smpTick = slowMode ? slowTick : gearTick;

  // ------------------------------------------------------------------
  // noise canceller: level passes after several equal samples
  // ------------------------------------------------------------------
  reg smpLast_nxt;
  reg [2:0] runCnt_nxt;
  reg filt_nxt;
  always @* begin
    smpLast_nxt = smpLast_r;
    runCnt_nxt = runCnt_r;
    filt_nxt = filt_r;
    if (smpTick) begin
      smpLast_nxt = extPin;
      if (extPin != smpLast_r) begin
        runCnt_nxt = 3'h1;
      end else if (runCnt_r < `FILT_SAMPLES) begin
        runCnt_nxt = runCnt_r + 3'h1;
      end
      // pass only once the run of equal samples reaches the threshold
      if ((extPin == smpLast_r) && (runCnt_r + 3'h1 >= `FILT_SAMPLES)) begin
        filt_nxt = extPin;
      end
    end
  end

  // filter starts low, like the idle pin, so no false edge follows reset
  always @(posedge mclk) begin
    if (rst) begin
      smpLast_r <= 1'b0;
      runCnt_r <= 3'h0;
      filt_r <= 1'b0;
      filtDly_r <= 1'b0;
    end else begin
      smpLast_r <= smpLast_nxt;
      runCnt_r <= runCnt_nxt;
      filt_r <= filt_nxt;
      filtDly_r <= filt_r;
    end
  end

  // ------------------------------------------------------------------
  // trigger detection
  // ------------------------------------------------------------------
  reg trigHit;
  always @* begin
    case (trigSel_r)
      `TRIG_RISE: trigHit = filt_r & ~filtDly_r;
      `TRIG_FALL: trigHit = ~filt_r & filtDly_r;
      `TRIG_BOTH: trigHit = filt_r ^ filtDly_r;
      `TRIG_HIGH: trigHit = filt_r;
      default: trigHit = 1'b0;
    endcase
  end
  assign reqEvent = trigHit;

  // ------------------------------------------------------------------
  // request output, level flag, sticky status and interrupt line
  // ------------------------------------------------------------------
  reg levelFlag_nxt;
  reg [7:0] stat_nxt;
  reg intOut_nxt;
  always @* begin
    levelFlag_nxt = levelFlag_r;
    stat_nxt = stat_r;
    if (reqEvent) begin
      levelFlag_nxt = filt_r;
    end
    // set wins over the read clear
    if (reqEvent) begin
      stat_nxt = stat_r | (8'h01 << `STAT_REQ_BIT);
    end else if (statRdClr) begin
      stat_nxt = `STAT_RESET;
    end
    // line follows the status it will hold, so it never lags the sticky bit
    intOut_nxt = |(stat_nxt & mask_r);
  end

  always @(posedge mclk) begin
    if (rst) begin
      irqReq <= 1'b0;
      levelFlag_r <= `LVL_RESET;
      stat_r <= `STAT_RESET;
      intOut <= 1'b0;
    end else begin
      irqReq <= reqEvent;
      levelFlag_r <= levelFlag_nxt;
      stat_r <= stat_nxt;
      intOut <= intOut_nxt;
    end
  end

endmodule // ext_irq4_edge_detect_ctrl

// file: ext_irq4_regs.vh
// register offsets, field positions, reset values and timing counts for external interrupt 4
`ifndef EXT_IRQ4_REGS_VH
`define EXT_IRQ4_REGS_VH

// control register index and derived byte address (printed offset not a multiple of four)
`define CTRL_INDEX 12'hFDB
`define CTRL_ADDR 14'h3F6C
// interrupt status and mask registers, indices following the control register
`define STAT_INDEX 12'hFDC
`define STAT_ADDR 14'h3F70
`define MASK_INDEX 12'hFDD
`define MASK_ADDR 14'h3F74

// control register fields
`define LVL_BIT 4
`define TRIG_HI 3
`define TRIG_LO 2
`define SMP_HI 1
`define SMP_LO 0
`define CTRL_RESET 8'h00
`define TRIG_RESET 2'h0
`define SMP_RESET 2'h0
`define LVL_RESET 1'b0

// trigger condition codes
`define TRIG_RISE 2'h0
`define TRIG_FALL 2'h1
`define TRIG_BOTH 2'h2
`define TRIG_HIGH 2'h3

// status bit positions
`define STAT_REQ_BIT 0
`define STAT_RESET 8'h00
`define MASK_RESET 8'h00

// noise filter: consecutive equal samples needed to pass a level
`define FILT_SAMPLES 3'h3
// low-frequency sample enable runs at low_freq_clock / 4
`define SLOW_DIV 2'h3

`endif

// file: ext_irq4_sva.sv
// port assertions for the external interrupt 4 block
`timescale 1ns/100ps
`include "ext_irq4_regs.vh"
module ext_irq4_sva (
  input wire mclk,
  input wire rst,
  input wire hsel,
  input wire [13:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire irqReq,
  input wire intOut
);
  // --------------------
  // bus and interrupt checks
  // --------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  wire rdTaken = hsel && hready && htrans[1] && !hwrite;
  wire wrMask = hsel && hready && htrans[1] && hwrite && haddr == `MASK_ADDR;
  reg seenReq;
  always @(posedge mclk) begin
    if (rst) seenReq <= 1'b0;
    else if (irqReq) seenReq <= 1'b1;
  end
  readyHigh_a: assert property (hreadyout) else $error("hreadyout low");
  respOkay_a: assert property (!hresp) else $error("hresp not okay");
  resetClr_a: assert property (disable iff (1'b0) rst |=> !irqReq && !intOut && !hrdata)
    else $error("outputs not cleared by reset");
  ctrlUpper_a: assert property (rdTaken && haddr == `CTRL_ADDR |=> !hrdata[31:5])
    else $error("control upper bits set");
  wordUpper_a: assert property (rdTaken |=> !hrdata[31:8]) else $error("word upper bits set");
  dataHold_a: assert property (!rdTaken |=> $stable(hrdata)) else $error("hrdata moved");
  intCause_a: assert property (intOut |-> seenReq || irqReq) else $error("intOut without request");
  maskOff_a: assert property (wrMask ##1 !hwdata[0] |=> ##1 !intOut)
    else $error("masked intOut high");
endmodule // ext_irq4_sva
bind ext_irq4_edge_detect_ctrl ext_irq4_sva chk (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .irqReq, .intOut);

// file: ext_pin_model.sv
// board signal driving the external interrupt pin
`timescale 1ns/100ps
module ext_pin_model (
  input wire mclk,
  output reg extPin
);
  // ----------
  // pin driver
  // ----------
  initial extPin = 1'b0;
  // hold a level for n cycles, changed just after an edge
  task drive(input logic v, input int n);
    extPin <= v;
    repeat (n) @(posedge mclk);
  endtask
endmodule // ext_pin_model

// file: ext_irq4_edge_detect_ctrl_test.sv
// self-checking bench for the external interrupt 4 block
`timescale 1ns/100ps
`include "ext_irq4_regs.vh"
module ext_irq4_edge_detect_ctrl_test;
  // ----------
  // bench
  // ----------
  reg mclk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0;
  reg gearClkEn = 1'b1, lowFreqClkEn = 1'b0, slowMode = 1'b0;
  reg [13:0] haddr = 14'h0;
  reg [1:0] htrans = 2'h0;
  reg [31:0] hwdata = 32'h0;
  wire [31:0] hrdata;
  wire hreadyout, hresp, irqReq, intOut, extPin;
  int fail_count = 0, tests_run = 0, reqCount = 0, base, iv;
  logic [31:0] rd;
  always #10 mclk = ~mclk;
  always @(posedge mclk) lowFreqClkEn <= ~lowFreqClkEn;
  always @(posedge mclk) if (irqReq === 1'b1) reqCount <= reqCount + 1;
  ext_irq4_edge_detect_ctrl DUT (.mclk, .rst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .extPin, .gearClkEn,
    .lowFreqClkEn, .slowMode, .irqReq, .intOut);
  ext_pin_model pin (.mclk, .extPin);
  task summarize;
    $display("checks %0d errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task waitReady;
    int n;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      summarize();
    end
  endtask
  task xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    waitReady();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    xfer(1'b0, `CTRL_ADDR, 32'h0);
    chk("ctrl", `CTRL_RESET, rd);
    xfer(1'b1, `CTRL_ADDR, 32'hFF);
    xfer(1'b0, `CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0F, rd);
    xfer(1'b0, 14'h0, 32'h0);
    chk("unmapped", 32'h0, rd);
    xfer(1'b1, `MASK_ADDR, 32'h1);
    for (int c = 0; c < 4; c++) begin
      xfer(1'b1, `CTRL_ADDR, c << 2);
      base = reqCount;
      pin.drive(1'b1, 12);
      pin.drive(1'b0, 12);
      if (c == 3) chk("reqs", 1, reqCount - base > 3);
      else chk("reqs", c == 2 ? 2 : 1, reqCount - base);
      chk("intOut", 1, intOut);
      xfer(1'b0, `CTRL_ADDR, 32'h0);
      chk("ctrl", {c[0] ~^ c[1], c[1:0], 2'h0}, rd);
      xfer(1'b0, `STAT_ADDR, 32'h0);
      chk("status", 32'h1, rd);
    end
    xfer(1'b0, `STAT_ADDR, 32'h0);
    chk("status", 32'h0, rd);
    chk("intOut", 0, intOut);
    for (int s = 0; s < 5; s++) begin
      iv = s == 4 ? 8 : s == 0 ? 1 : 2 << s;
      slowMode <= s == 4;
      xfer(1'b1, `CTRL_ADDR, s & 3);
      base = reqCount;
      pin.drive(1'b1, 2 * iv);
      pin.drive(1'b0, 4 * iv + 4);
      chk("glitch", 0, reqCount - base);
      pin.drive(1'b1, 4 * iv + 4);
      pin.drive(1'b0, 4 * iv + 4);
      chk("reqs", 1, reqCount - base);
    end
    xfer(1'b1, `MASK_ADDR, 32'h0);
    summarize();
  end
endmodule // ext_irq4_edge_detect_ctrl_test
